//--- design/tcsa_pkg.sv
// Constants, types and register map of the Type-C source attach output block
package tcsa_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_ALERT_MASK   = 8'h0C;
    localparam logic [7:0] ADDR_CONN_STATUS  = 8'h0E;
    localparam logic [7:0] ADDR_OP_STATE     = 8'h11;
    localparam logic [7:0] ADDR_RESET_CTRL   = 8'h23;
    localparam logic [7:0] ADDR_DISCHARGE    = 8'h25;
    localparam logic [7:0] ADDR_PORT_ROLE    = 8'h28;
    localparam logic [7:0] ADDR_SUPPLY_MON   = 8'h2E;

    // Field positions
    localparam int ALERT_ATTACH_BIT  = 0;
    localparam int ALERT_MONITOR_BIT = 4;
    localparam int ALERT_FAULT_BIT   = 5;
    localparam int SOFT_RESET_BIT    = 0;
    localparam int DISCH_LSB         = 0;
    localparam int DISCH_W           = 4;
    localparam int ROLE_LSB          = 0;
    localparam int ROLE_W            = 3;
    localparam int OVLO_OFF_BIT      = 6;
    localparam int VALID_OFF_BIT     = 4;
    localparam int SAFE0_LSB         = 1;
    localparam int SAFE0_W           = 2;
    localparam int UVLO_OFF_BIT      = 0;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] ALERT_WMASK  = 8'h31;
    localparam logic [7:0] RESET_WMASK  = 8'h01;
    localparam logic [7:0] DISCH_WMASK  = 8'h0F;
    localparam logic [7:0] ROLE_WMASK   = 8'h07;
    localparam logic [7:0] SUPPLY_WMASK = 8'h57;

    // Reset values
    localparam logic [7:0] ALERT_RESET  = 8'h31;
    localparam logic [7:0] RESET_RESET  = 8'h00;
    localparam logic [7:0] DISCH_RESET  = 8'h0A;
    localparam logic [7:0] SUPPLY_RESET = 8'h01;

    // Port role codes
    localparam logic [2:0] ROLE_SRC_ACC = 3'h0;
    localparam logic [2:0] ROLE_SNK_ACC = 3'h1;

    // Connection status codes
    localparam logic [7:0] STAT_NONE    = 8'h00;
    localparam logic [7:0] STAT_SINK    = 8'h2D;
    localparam logic [7:0] STAT_SINK_VC = 8'h2F;
    localparam logic [7:0] STAT_DEBUG   = 8'h6D;
    localparam logic [7:0] STAT_AUDIO   = 8'h81;

    // Termination seen on one CC line, from the analog comparators
    typedef enum logic [2:0] {
        TERM_OPEN  = 3'b000,
        TERM_RA    = 3'b001,
        TERM_RD    = 3'b010,
        TERM_RP    = 3'b011,
        TERM_SUBRA = 3'b100
    } tcsa_term_e;

    // Attach state, also the low bits of the operation state register
    typedef enum logic [2:0] {
        ST_UNATT_SRC = 3'b000,
        ST_ATT_SRC   = 3'b001,
        ST_UNOR_DBG  = 3'b010,
        ST_OR_DBG    = 3'b011,
        ST_AUDIO     = 3'b100
    } tcsa_attach_e;

    // Analog monitor levels
    typedef struct packed {
        logic vdd_present;
        logic vdd_below_ovlo;
        logic vdd_above_uvlo;
        logic vbus_in_valid;
        logic vbus_above_uvlo;
        logic sys_above_min;
    } tcsa_sense_s;

    // Termination pair of both CC lines
    typedef struct packed {
        tcsa_term_e cc1;
        tcsa_term_e cc2;
    } tcsa_cc_s;

endpackage

//--- design/tcsa_sync.sv
// Two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module tcsa_sync #(
    parameter int                W         = 1,
    parameter logic [W-1:0]      RESET_VAL = '0
) (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic [W-1:0]    d,
    output logic      [W-1:0]    q
);
    logic [W-1:0] meta_q;

    // First stage is read by the second stage only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // tcsa_sync

//--- design/tcsa_source_attach.sv
// Source role attach outputs, status and configuration registers
//
// Function
// - Power-path enable pulls low only in attached source or debug source states.
// - With high-voltage supply present, it must be below over-voltage lockout.
// - Power enable needs attach state, supply check and VBUS check together.
// - Power enable released as soon as any enabling condition fails.
// - Single sink: attached, power on, no VCONN, 2Dh, orientation low if CC2.
// - Sink plus cable: VCONN on cable line, power on, status 2Fh.
// - Sink both lines unoriented debug; sink plus sub-Ra oriented; 6Dh, power on.
// - Oriented debug: orientation low for sink on CC2, released for CC1.
// - Source terminations on both lines stay unattached, all off, 00h.
// - Cable terminations both lines: audio accessory, power and VCONN off, 81h.
// - Open lines or lone cable: unattached, outputs released, VCONN off, 00h.
// - Status may show transient codes; software tolerates them.
// - System supply chosen above its minimum or with high-voltage supply absent, else high-voltage supply.
// - Role field 000b means source with accessory support.
// - Role field 001b means sink with accessory support.
// - Discharge duration field resets to 1010b, 840 ms.
// - Soft reset select resets to 0, hardware reset only.
// - Safe-zero level field resets to 00b, 0.6 V.
// - Valid window disable resets to 0, window gates power enable.
// - Attach, monitor and fault alert masks reset to 1.
// - With over-voltage check on, power only while supply below 6.0 V.
// - With under-voltage check on, power only while supply above 3.9 V.
`timescale 1ns/1ps
module tcsa_source_attach
    import tcsa_pkg::*;
#(
    parameter logic [2:0] ROLE_RESET = ROLE_SRC_ACC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire tcsa_cc_s          cc_term,
    input  wire tcsa_sense_s       sense,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    output logic                   source_power_enable_o,
    output logic                   source_power_enable_oe,
    output logic                   orientation_o,
    output logic                   orientation_oe,
    output logic                   vconn_cc1_en,
    output logic                   vconn_cc2_en,
    output logic                   system_supply_select,
    output logic                   soft_reset_select,
    output logic [DISCH_W-1:0]     discharge_duration,
    output logic [SAFE0_W-1:0]     safe_zero_level_select
);

    // Reset release through two flip-flops
    logic rst_sync_n;

    tcsa_sync #(.W(1), .RESET_VAL(1'b0)) u_rst_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (1'b1),
        .q       (rst_sync_n)
    );

    // Pin levels from the analog front end are asynchronous
    localparam int IN_W = $bits(tcsa_cc_s) + $bits(tcsa_sense_s);
    tcsa_cc_s    cc_s;
    tcsa_sense_s sns_s;

    // Held with the core so no decode starts before the registers leave reset
    tcsa_sync #(.W(IN_W), .RESET_VAL('0)) u_in_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_sync_n),
        .d       ({cc_term, sense}),
        .q       ({cc_s, sns_s})
    );

    // Configuration registers
    logic [7:0] alert_q, alert_d;
    logic [7:0] rstctl_q, rstctl_d;
    logic [7:0] disch_q, disch_d;
    logic [7:0] role_q, role_d;
    logic [7:0] supmon_q, supmon_d;
    logic [7:0] rdata_d;

    // Attach state and outputs
    tcsa_attach_e att_q, att_d;
    logic [7:0]   stat_q, stat_d;
    logic         pwr_q, pwr_d;
    logic         orient_q, orient_d;
    logic         vc1_q, vc1_d;
    logic         vc2_q, vc2_d;
    logic         sys_sel_q, sys_sel_d;
    logic         ovlo_ok, uvlo_ok, vbus_ok, att_pwr;

    always_comb begin
        alert_d  = alert_q;
        rstctl_d = rstctl_q;
        disch_d  = disch_q;
        role_d   = role_q;
        supmon_d = supmon_q;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_ALERT_MASK: alert_d  = reg_wdata & ALERT_WMASK;
                ADDR_RESET_CTRL: rstctl_d = reg_wdata & RESET_WMASK;
                ADDR_DISCHARGE:  disch_d  = reg_wdata & DISCH_WMASK;
                ADDR_PORT_ROLE:  role_d   = reg_wdata & ROLE_WMASK;
                ADDR_SUPPLY_MON: supmon_d = reg_wdata & SUPPLY_WMASK;
                default: ;
            endcase
        end
        // Read data lags the address by one cycle; unmapped reads as zero
        case (reg_addr)
            ADDR_ALERT_MASK:  rdata_d = alert_q;
            ADDR_CONN_STATUS: rdata_d = stat_q;
            ADDR_OP_STATE:    rdata_d = {5'h00, att_q};
            ADDR_RESET_CTRL:  rdata_d = rstctl_q;
            ADDR_DISCHARGE:   rdata_d = disch_q;
            ADDR_PORT_ROLE:   rdata_d = role_q;
            ADDR_SUPPLY_MON:  rdata_d = supmon_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alert_q   <= ALERT_RESET;
            rstctl_q  <= RESET_RESET;
            disch_q   <= DISCH_RESET;
            role_q    <= {5'h00, ROLE_RESET};
            supmon_q  <= SUPPLY_RESET;
            reg_rdata <= 8'h00;
        end else begin
            alert_q   <= alert_d;
            rstctl_q  <= rstctl_d;
            disch_q   <= disch_d;
            role_q    <= role_d;
            supmon_q  <= supmon_d;
            reg_rdata <= rdata_d;
        end
    end

    // Attach decode; only the source role attaches, other roles idle here
    always_comb begin
        att_d    = ST_UNATT_SRC;
        orient_d = 1'b0;
        vc1_d    = 1'b0;
        vc2_d    = 1'b0;
        if (role_q[ROLE_LSB +: ROLE_W] == ROLE_SRC_ACC) begin
            if (cc_s.cc1 == TERM_RD && cc_s.cc2 == TERM_RD) begin
                att_d = ST_UNOR_DBG;
            end else if (cc_s.cc1 == TERM_RD && cc_s.cc2 == TERM_SUBRA) begin
                att_d = ST_OR_DBG;
            end else if (cc_s.cc1 == TERM_SUBRA && cc_s.cc2 == TERM_RD) begin
                att_d    = ST_OR_DBG;
                orient_d = 1'b1;
            end else if (cc_s.cc1 == TERM_RD && (cc_s.cc2 == TERM_OPEN || cc_s.cc2 == TERM_RA)) begin
                att_d = ST_ATT_SRC;
                vc2_d = (cc_s.cc2 == TERM_RA);
            end else if (cc_s.cc2 == TERM_RD && (cc_s.cc1 == TERM_OPEN || cc_s.cc1 == TERM_RA)) begin
                att_d    = ST_ATT_SRC;
                orient_d = 1'b1;
                vc1_d    = (cc_s.cc1 == TERM_RA);
            end else if (cc_s.cc1 == TERM_RA && cc_s.cc2 == TERM_RA) begin
                att_d = ST_AUDIO;
            end
            // Rp on both, open, lone cable: stay unattached
        end
        case (att_d)
            ST_ATT_SRC:  stat_d = (vc1_d || vc2_d) ? STAT_SINK_VC : STAT_SINK;
            ST_UNOR_DBG: stat_d = STAT_DEBUG;
            ST_OR_DBG:   stat_d = STAT_DEBUG;
            ST_AUDIO:    stat_d = STAT_AUDIO;
            default:     stat_d = STAT_NONE;
        endcase
    end

    // Supply and VBUS checks, evaluated fresh every cycle
    always_comb begin
        ovlo_ok   = !sns_s.vdd_present || supmon_q[OVLO_OFF_BIT] || sns_s.vdd_below_ovlo;
        uvlo_ok   = !sns_s.vdd_present || supmon_q[UVLO_OFF_BIT] || sns_s.vdd_above_uvlo;
        // Window off falls back to the VBUS under-voltage level
        vbus_ok   = supmon_q[VALID_OFF_BIT] ? sns_s.vbus_above_uvlo : sns_s.vbus_in_valid;
        att_pwr   = (att_d == ST_ATT_SRC) || (att_d == ST_UNOR_DBG) || (att_d == ST_OR_DBG);
        pwr_d     = att_pwr && ovlo_ok && uvlo_ok && vbus_ok;
        sys_sel_d = sns_s.sys_above_min || !sns_s.vdd_present;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            att_q     <= ST_UNATT_SRC;
            stat_q    <= STAT_NONE;
            pwr_q     <= 1'b0;
            orient_q  <= 1'b0;
            vc1_q     <= 1'b0;
            vc2_q     <= 1'b0;
            sys_sel_q <= 1'b0;
        end else begin
            att_q     <= att_d;
            stat_q    <= stat_d;
            pwr_q     <= pwr_d;
            orient_q  <= orient_d;
            vc1_q     <= vc1_d;
            vc2_q     <= vc2_d;
            sys_sel_q <= sys_sel_d;
        end
    end

    // Open-drain pins only ever pull low, so the level flop stays at zero
    logic drive_low_q;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            drive_low_q <= 1'b0;
        end else begin
            drive_low_q <= 1'b0;
        end
    end

    assign source_power_enable_o  = drive_low_q;
    assign source_power_enable_oe = pwr_q;
    assign orientation_o          = drive_low_q;
    assign orientation_oe         = orient_q;
    assign vconn_cc1_en           = vc1_q;
    assign vconn_cc2_en           = vc2_q;
    assign system_supply_select   = sys_sel_q;
    assign soft_reset_select      = rstctl_q[SOFT_RESET_BIT];
    assign discharge_duration     = disch_q[DISCH_LSB +: DISCH_W];
    assign safe_zero_level_select = supmon_q[SAFE0_LSB +: SAFE0_W];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    logic pwr_state;
    assign pwr_state = (att_q == ST_ATT_SRC) || (att_q == ST_UNOR_DBG) || (att_q == ST_OR_DBG);

    pwr_state_only_a: assert property (source_power_enable_oe |-> pwr_state)
        else $error("power enable outside an attached source state");
    pwr_ovlo_gate_a: assert property ($past(sns_s.vdd_present && !sns_s.vdd_below_ovlo
        && !supmon_q[OVLO_OFF_BIT]) |-> !source_power_enable_oe)
        else $error("power enable while supply above lockout");
    pwr_all_cond_a: assert property ($past(att_pwr && ovlo_ok && uvlo_ok && vbus_ok)
        |-> source_power_enable_oe)
        else $error("power enable missing with all conditions met");
    pwr_release_a: assert property ($past(!vbus_ok) |-> !source_power_enable_oe)
        else $error("power enable held with VBUS out of range");
    sink_cc2_a: assert property (cc_s.cc1 == TERM_OPEN && cc_s.cc2 == TERM_RD
        && role_q[2:0] == ROLE_SRC_ACC |=> att_q == ST_ATT_SRC && stat_q == STAT_SINK
        && orientation_oe && !vconn_cc1_en && !vconn_cc2_en)
        else $error("single sink on CC2 decoded wrongly");
    cable_vconn_a: assert property (cc_s.cc1 == TERM_RD && cc_s.cc2 == TERM_RA
        && role_q[2:0] == ROLE_SRC_ACC |=> vconn_cc2_en && !vconn_cc1_en && stat_q == STAT_SINK_VC)
        else $error("VCONN not on cable line");
    debug_code_a: assert property (att_q inside {ST_UNOR_DBG, ST_OR_DBG} |-> stat_q == STAT_DEBUG)
        else $error("debug state without 6Dh");
    orient_dbg_a: assert property (cc_s.cc1 == TERM_RD && cc_s.cc2 == TERM_SUBRA
        && role_q[2:0] == ROLE_SRC_ACC |=> att_q == ST_OR_DBG && !orientation_oe)
        else $error("oriented debug orientation wrong");
    rp_both_a: assert property (cc_s.cc1 == TERM_RP && cc_s.cc2 == TERM_RP
        |=> att_q == ST_UNATT_SRC && stat_q == STAT_NONE && !vconn_cc1_en)
        else $error("Rp on both lines attached");
    audio_off_a: assert property (att_q == ST_AUDIO |-> stat_q == STAT_AUDIO
        && !source_power_enable_oe && !orientation_oe && !vconn_cc1_en && !vconn_cc2_en)
        else $error("audio accessory outputs wrong");
    unatt_quiet_a: assert property (att_q == ST_UNATT_SRC |-> stat_q == STAT_NONE
        && !source_power_enable_oe && !orientation_oe && !vconn_cc1_en && !vconn_cc2_en)
        else $error("unattached with active outputs");
    supply_pick_a: assert property ($past(sns_s.vdd_present && !sns_s.sys_above_min)
        |-> !system_supply_select)
        else $error("system supply chosen below its minimum");
    sink_role_idle_a: assert property (role_q[2:0] == ROLE_SNK_ACC |=> att_q == ST_UNATT_SRC)
        else $error("source attach in sink role");
    uvlo_gate_a: assert property ($past(sns_s.vdd_present && !sns_s.vdd_above_uvlo
        && !supmon_q[UVLO_OFF_BIT]) |-> !source_power_enable_oe)
        else $error("power enable with supply below under-voltage level");
    stat_with_state_a: assert property ($changed(att_q) |-> $changed(stat_q)
        || att_q inside {ST_UNOR_DBG, ST_OR_DBG})
        else $error("status not updated with attach state");
    status_idle_a: assert property (stat_q == STAT_NONE |-> att_q == ST_UNATT_SRC)
        else $error("status idle while attached");
    // Power terms use the synchronised sense one edge back, as the output flop does
    vbus_window_a: assert property ($past(!supmon_q[VALID_OFF_BIT] && !sns_s.vbus_in_valid)
        |-> !source_power_enable_oe)
        else $error("power enable with VBUS outside its window");
    supply_high_a: assert property ($past(sns_s.sys_above_min) |-> system_supply_select)
        else $error("system supply not chosen above its minimum");
    // Both VCONN switches on would short the cable supply
    vconn_exclusive_a: assert property (!(vconn_cc1_en && vconn_cc2_en))
        else $error("VCONN on both lines");
    vconn_cc1_a: assert property (vconn_cc1_en |-> att_q == ST_ATT_SRC
        && stat_q == STAT_SINK_VC && orientation_oe)
        else $error("VCONN on CC1 without a sink on CC2");
    sink_cc1_a: assert property (cc_s.cc1 == TERM_RD && cc_s.cc2 == TERM_OPEN
        && role_q[2:0] == ROLE_SRC_ACC |=> stat_q == STAT_SINK && !orientation_oe)
        else $error("single sink on CC1 decoded wrongly");
    role_idle_a: assert property (role_q[2:0] != ROLE_SRC_ACC |=> att_q == ST_UNATT_SRC)
        else $error("attach outside the source role");

    attach_seen_c: cover property (att_q == ST_UNATT_SRC ##1 att_q == ST_ATT_SRC ##1 source_power_enable_oe);
    vconn_seen_c:  cover property (vconn_cc1_en && stat_q == STAT_SINK_VC);
    debug_seen_c:  cover property (att_q == ST_OR_DBG && orientation_oe);
    audio_seen_c:  cover property (att_q == ST_AUDIO);
    unor_debug_c:  cover property (att_q == ST_UNOR_DBG && source_power_enable_oe);

endmodule // tcsa_source_attach

//--- tb/tcsa_cc_partner.sv
// Port partner model presenting CC terminations, prompt or slow to settle
`timescale 1ns/1ps
module tcsa_cc_partner
    import tcsa_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      slow,
    input  wire tcsa_cc_s  plug,
    output tcsa_cc_s       cc_term
);
    logic [2:0] age_q;

    initial begin
        cc_term = '{cc1: TERM_OPEN, cc2: TERM_OPEN};
        age_q   = 3'h0;
    end

    // A slow plug keeps its old termination for a few cycles, as a real contact does while mating
    always @(posedge sys_clk) begin
        if (plug != cc_term && (!slow || age_q == 3'h3)) begin
            cc_term <= plug;
            age_q   <= 3'h0;
        end else if (plug != cc_term) begin
            age_q <= age_q + 3'h1;
        end
    end
endmodule // tcsa_cc_partner

//--- tb/tb_typec_source_attach_outputs.sv
// Self-checking testbench of the source attach output block
`timescale 1ns/1ps
module tb_typec_source_attach_outputs
    import tcsa_pkg::*;
;
    typedef struct {tcsa_term_e a; tcsa_term_e b; logic [3:0] p; logic [7:0] st; logic [7:0] op;} tcsa_row_s;

    logic                 sys_clk, rst_n, reg_wr, slow;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata, rd_v;
    tcsa_sense_s          sense;
    tcsa_cc_s             plug, cc_term;
    logic                 source_power_enable_o, source_power_enable_oe, orientation_o, orientation_oe;
    logic                 vconn_cc1_en, vconn_cc2_en, system_supply_select, soft_reset_select;
    logic [DISCH_W-1:0]   discharge_duration;
    logic [SAFE0_W-1:0]   safe_zero_level_select;
    int                   bad_count, checks_done;

    // Pins: {power enable, orientation, vconn cc1, vconn cc2}
    tcsa_row_s rows [12] = '{
        '{TERM_OPEN, TERM_OPEN, 4'h0, 8'h00, 8'h00}, '{TERM_RD, TERM_OPEN, 4'h8, 8'h2D, 8'h01},
        '{TERM_OPEN, TERM_RD, 4'hC, 8'h2D, 8'h01}, '{TERM_OPEN, TERM_RA, 4'h0, 8'h00, 8'h00},
        '{TERM_RA, TERM_OPEN, 4'h0, 8'h00, 8'h00}, '{TERM_RD, TERM_RA, 4'h9, 8'h2F, 8'h01},
        '{TERM_RA, TERM_RD, 4'hE, 8'h2F, 8'h01}, '{TERM_RP, TERM_RP, 4'h0, 8'h00, 8'h00},
        '{TERM_RD, TERM_RD, 4'h8, 8'h6D, 8'h02}, '{TERM_RD, TERM_SUBRA, 4'h8, 8'h6D, 8'h03},
        '{TERM_SUBRA, TERM_RD, 4'hC, 8'h6D, 8'h03}, '{TERM_RA, TERM_RA, 4'h0, 8'h81, 8'h04}};

    tcsa_cc_partner tcsa_cc_partner_i (.sys_clk(sys_clk), .slow(slow), .plug(plug), .cc_term(cc_term));

    tcsa_source_attach tcsa_source_attach_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .cc_term(cc_term), .sense(sense), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .source_power_enable_o(source_power_enable_o), .source_power_enable_oe(source_power_enable_oe),
        .orientation_o(orientation_o), .orientation_oe(orientation_oe), .vconn_cc1_en(vconn_cc1_en),
        .vconn_cc2_en(vconn_cc2_en), .system_supply_select(system_supply_select),
        .soft_reset_select(soft_reset_select), .discharge_duration(discharge_duration),
        .safe_zero_level_select(safe_zero_level_select));

    function automatic logic [3:0] pins();
        return {source_power_enable_oe, orientation_oe, vconn_cc1_en, vconn_cc2_en};
    endfunction

    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pin(input string name, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        tick(2);
        v = reg_rdata;
    endtask

    // Inputs pass two sync flops and one output flop, so five edges cover a prompt change
    task automatic connect(input tcsa_term_e a, input tcsa_term_e b, input logic sl);
        @(posedge sys_clk);
        plug <= '{cc1: a, cc2: b};
        slow <= sl;
        tick(sl ? 12 : 5);
    endtask

    task automatic sn(input logic [5:0] s, input int n);
        @(posedge sys_clk);
        sense <= tcsa_sense_s'(s);
        tick(n);
    endtask

    task automatic t_reset_values();
        logic [7:0] al [8] = '{ADDR_ALERT_MASK, ADDR_RESET_CTRL, ADDR_DISCHARGE, ADDR_PORT_ROLE,
                               ADDR_SUPPLY_MON, ADDR_CONN_STATUS, ADDR_OP_STATE, 8'h30};
        logic [7:0] el [8] = '{8'h31, 8'h00, 8'h0A, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(al[i], rd_v);
            chk_reg("reset_value", el[i], rd_v);
        end
        chk_pin("discharge_duration", 4'hA, discharge_duration);
        chk_pin("cfg_bits", 4'h0, {1'b0, soft_reset_select, safe_zero_level_select});
        $display("test reset_values done");
    endtask

    task automatic t_attach_table();
        for (int i = 0; i < 12; i++) begin
            connect(rows[i].a, rows[i].b, i[0]);
            chk_pin("cc_pins", rows[i].p, pins());
            chk_pin("drive_levels", 4'h0, {2'b00, source_power_enable_o, orientation_o});
            rd(ADDR_CONN_STATUS, rd_v);
            chk_reg("conn_status", rows[i].st, rd_v);
            rd(ADDR_OP_STATE, rd_v);
            chk_reg("op_state", rows[i].op, rd_v);
            connect(TERM_OPEN, TERM_OPEN, 1'b0);
        end
        $display("test attach_table done");
    endtask

    task automatic t_power_gating();
        connect(TERM_RD, TERM_OPEN, 1'b0);
        chk_pin("pwr_all_ok", 4'h8, pins());
        sn(6'h3B, 2);
        chk_pin("pwr_before_release", 4'h8, pins());
        tick(1);
        chk_pin("pwr_vbus_invalid", 4'h0, pins());
        sn(6'h2F, 4);
        chk_pin("pwr_over_ovlo", 4'h0, pins());
        sn(6'h0F, 4);
        chk_pin("pwr_vdd_absent", 4'h8, pins());
        chk_pin("supply_vdd_absent", 4'h1, {3'b000, system_supply_select});
        sn(6'h3E, 4);
        chk_pin("supply_sys_low", 4'h0, {3'b000, system_supply_select});
        wr(ADDR_SUPPLY_MON, 8'h41);
        sn(6'h2F, 4);
        chk_pin("pwr_ovlo_off", 4'h8, pins());
        wr(ADDR_SUPPLY_MON, 8'h00);
        sn(6'h37, 4);
        chk_pin("pwr_under_uvlo", 4'h0, pins());
        sn(6'h3F, 4);
        chk_pin("pwr_uvlo_ok", 4'h8, pins());
        chk_pin("supply_sys_high", 4'h1, {3'b000, system_supply_select});
        wr(ADDR_SUPPLY_MON, 8'h11);
        sn(6'h3B, 4);
        chk_pin("pwr_window_off", 4'h8, pins());
        sn(6'h39, 4);
        chk_pin("pwr_vbus_uvlo", 4'h0, pins());
        wr(ADDR_SUPPLY_MON, 8'h01);
        sn(6'h3F, 4);
        connect(TERM_OPEN, TERM_OPEN, 1'b0);
        $display("test power_gating done");
    endtask

    task automatic t_reg_access();
        logic [7:0] al [6] = '{ADDR_ALERT_MASK, ADDR_DISCHARGE, ADDR_RESET_CTRL, ADDR_SUPPLY_MON,
                               ADDR_CONN_STATUS, 8'h30};
        logic [7:0] wl [6] = '{8'hFF, 8'hF5, 8'hFF, 8'hFF, 8'h55, 8'hAA};
        logic [7:0] el [6] = '{8'h31, 8'h05, 8'h01, 8'h57, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            wr(al[i], wl[i]);
            rd(al[i], rd_v);
            chk_reg("reg_readback", el[i], rd_v);
        end
        chk_pin("cfg_outputs", 4'hF, {soft_reset_select, discharge_duration[2], safe_zero_level_select});
        wr(ADDR_SUPPLY_MON, 8'h01);
        wr(ADDR_PORT_ROLE, 8'h01);
        rd(ADDR_PORT_ROLE, rd_v);
        chk_reg("role_sink", 8'h01, rd_v);
        connect(TERM_RD, TERM_OPEN, 1'b0);
        chk_pin("sink_role_pins", 4'h0, pins());
        wr(ADDR_PORT_ROLE, 8'hFF);
        rd(ADDR_PORT_ROLE, rd_v);
        chk_reg("role_masked", 8'h07, rd_v);
        wr(ADDR_PORT_ROLE, 8'h00);
        rd(ADDR_CONN_STATUS, rd_v);
        tick(3);
        rd(ADDR_CONN_STATUS, rd_v);
        chk_reg("role_source_status", 8'h2D, rd_v);
        chk_pin("role_source_pins", 4'h8, pins());
        connect(TERM_OPEN, TERM_OPEN, 1'b0);
        $display("test reg_access done");
    endtask

    task automatic results();
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        bad_count++;
        $display("[FAIL] watchdog expected done seen timeout");
        results();
    end

    initial begin
        rst_n       = 1'b0;
        reg_wr      = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        slow        = 1'b0;
        plug        = '{cc1: TERM_OPEN, cc2: TERM_OPEN};
        sense       = tcsa_sense_s'(6'h3F);
        bad_count   = 0;
        checks_done = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(3);
        t_reset_values();
        t_attach_table();
        t_power_gating();
        t_reg_access();
        results();
    end
endmodule // tb_typec_source_attach_outputs
